// ### asp_pkg.sv
// constants and types shared by the asynchronous serial port
package asp_pkg;

    // ----------------------------------------------------------------
    // register addresses on the internal bus
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_MODE = 16'hFFA0;
    localparam logic [15:0] ADDR_STAT = 16'hFFA1;
    localparam logic [15:0] ADDR_BRG  = 16'hFFA2;
    localparam logic [15:0] ADDR_DATA = 16'hFFA3;

    // ----------------------------------------------------------------
    // field layouts
    // ----------------------------------------------------------------
    localparam int MODE_TXE_BIT  = 7;
    localparam int MODE_RXE_BIT  = 6;
    localparam int MODE_PS_HI    = 5;
    localparam int MODE_PS_LO    = 4;
    localparam int MODE_CL_BIT   = 3;
    localparam int MODE_SL_BIT   = 2;
    localparam int STAT_PE_BIT   = 2;
    localparam int STAT_FE_BIT   = 1;
    localparam int STAT_OVE_BIT  = 0;
    localparam int BRG_TPS_HI    = 6;
    localparam int BRG_TPS_LO    = 4;
    localparam int BRG_MDL_HI    = 3;
    localparam int BRG_MDL_LO    = 0;
    localparam logic [7:0] MODE_MASK = 8'hFE;
    localparam logic [7:0] BRG_MASK  = 8'h7F;

    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [1:0] PS_NONE  = 2'h0;
    localparam logic [1:0] PS_ZERO  = 2'h1;
    localparam logic [1:0] PS_ODD   = 2'h2;
    localparam logic [1:0] PS_EVEN  = 2'h3;
    localparam logic [2:0] LAST_7   = 3'h6;
    localparam logic [2:0] LAST_8   = 3'h7;
    localparam logic [2:0] TPS_OFF  = 3'h0;
    localparam logic [3:0] MDL_OFF  = 4'hF;
    localparam logic [4:0] MDL_BASE = 5'h0F;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ   = 50000000;
    localparam int MIDI_BPS = 31250;
    localparam logic [11:0] MIDI_HALF = 12'(CLK_HZ / MIDI_BPS / 2);
    localparam logic [2:0]  MIDI_TPS  = 3'h5;
    localparam logic [3:0]  MIDI_MDL  = 4'h9;

    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2}
        asp_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_state_t;

endpackage : asp_pkg

// ### asp_baud_gen.sv
// half-bit tick generator: 2^n prescaler then divide by k+16
`timescale 1ns/1ps
module asp_baud_gen (
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] tps_i,
    input  wire logic [3:0] mdl_i,
    output logic            half_tick_o
);

    typedef struct packed {
        logic [6:0] pre;
        logic [4:0] div;
        logic       tick;
    } asp_baud_state_t;

    asp_baud_state_t r;
    asp_baud_state_t n;
    logic            pre_end;
    logic            div_end;

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    always_comb begin
        n       = r;
        n.tick  = 1'b0;
        pre_end = r.pre == 7'((8'h01 << tps_i) - 8'h01);
        div_end = r.div == (5'(mdl_i) + asp_pkg::MDL_BASE);
        // idle or prohibited settings clear the counters, so a start is always aligned
        if (!run_i || tps_i == asp_pkg::TPS_OFF || mdl_i == asp_pkg::MDL_OFF) begin
            n.pre = 7'h00;
            n.div = 5'h00;
        end else begin
            n.pre = pre_end ? 7'h00 : r.pre + 7'h01;
            if (pre_end) begin
                n.div  = div_end ? 5'h00 : r.div + 5'h01;
                n.tick = div_end;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign half_tick_o = r.tick;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [11:0] gap_r;
    logic        clean_r;
    logic        midi;
    assign midi = tps_i == asp_pkg::MIDI_TPS && mdl_i == asp_pkg::MIDI_MDL;

    always_ff @(posedge clock_i) begin
        if (srst_i || !run_i) begin
            gap_r   <= 12'h000;
            clean_r <= 1'b1;
        end else begin
            gap_r   <= half_tick_o ? 12'h001 : gap_r + 12'h001;
            clean_r <= half_tick_o ? 1'b1 : clean_r && midi;
        end
    end

    midi_period_a: assert property (@(posedge clock_i) disable iff (srst_i)
        half_tick_o && clean_r && midi |-> gap_r == asp_pkg::MIDI_HALF)
        else $error("half-bit period wrong at the 31.25 kbps setting");

endmodule : asp_baud_gen

// ### asp_serial_port.sv
// asynchronous serial port: bus registers, transmitter and receiver
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module asp_serial_port (
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_rd_i,
    input  wire logic [7:0]  bus_wdata_i,
    output logic      [7:0]  bus_rdata_o,
    input  wire logic        serial_in_pin_i,
    output logic             serial_out_pin_o
);

    typedef struct packed {
        logic [7:0]            async_mode_reg;
        logic [7:0]            async_error_status_reg;
        logic [7:0]            baud_gen_ctrl_reg;
        logic [7:0]            tx_shift_data;
        logic [7:0]            rx_buffer_data;
        logic [7:0]            rd_data;
        logic                  unread;
        asp_pkg::asp_tx_state_t tx_state;
        logic [7:0]            tx_sh;
        logic [2:0]            tx_cnt;
        logic                  tx_phase;
        logic                  tx_par;
        logic                  txd;
        logic [1:0]            rx_sync;
        logic                  rx_prev;
        asp_pkg::asp_rx_state_t rx_state;
        logic [7:0]            rx_shift_reg;
        logic [2:0]            rx_cnt;
        logic                  rx_phase;
        logic                  rx_par;
    } asp_state_t;

    asp_state_t r;
    asp_state_t n;
    logic       tx_tick;
    logic       rx_tick;
    logic       tx_load;
    logic       rx_done;
    logic       stop_ok;
    logic       line;
    logic [1:0] ps;
    logic [2:0] last;
    logic [7:0] tx_word;
    logic [7:0] rx_word;
    logic [7:0] stat;

    // ----------------------------------------------------------------
    // baud generators, one per direction so each can realign
    // ----------------------------------------------------------------
    asp_baud_gen u_tx_baud (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .run_i       (r.tx_state != asp_pkg::TX_IDLE),
        .tps_i       (r.baud_gen_ctrl_reg[asp_pkg::BRG_TPS_HI:asp_pkg::BRG_TPS_LO]),
        .mdl_i       (r.baud_gen_ctrl_reg[asp_pkg::BRG_MDL_HI:asp_pkg::BRG_MDL_LO]),
        .half_tick_o (tx_tick)
    );

    asp_baud_gen u_rx_baud (
        .clock_i     (clock_i),
        .srst_i      (srst_i),
        .run_i       (r.rx_state != asp_pkg::RX_IDLE),
        .tps_i       (r.baud_gen_ctrl_reg[asp_pkg::BRG_TPS_HI:asp_pkg::BRG_TPS_LO]),
        .mdl_i       (r.baud_gen_ctrl_reg[asp_pkg::BRG_MDL_HI:asp_pkg::BRG_MDL_LO]),
        .half_tick_o (rx_tick)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        n         = r;
        rx_done   = 1'b0;
        stop_ok   = 1'b0;
        n.rd_data = asp_pkg::RST_CTRL;
        ps        = r.async_mode_reg[asp_pkg::MODE_PS_HI:asp_pkg::MODE_PS_LO];
        last      = r.async_mode_reg[asp_pkg::MODE_CL_BIT] ? asp_pkg::LAST_8 : asp_pkg::LAST_7;
        line      = r.rx_sync[1];
        n.rx_sync = {r.rx_sync[0], serial_in_pin_i};
        n.rx_prev = line;
        tx_load   = bus_wr_i && bus_addr_i == asp_pkg::ADDR_DATA;
        tx_word   = r.async_mode_reg[asp_pkg::MODE_CL_BIT] ? bus_wdata_i
                                                           : {1'b0, bus_wdata_i[6:0]};
        rx_word   = r.async_mode_reg[asp_pkg::MODE_CL_BIT] ? r.rx_shift_reg
                                                           : {1'b0, r.rx_shift_reg[7:1]};
        stat      = asp_pkg::RST_CTRL;

        // bus writes; the receive buffer has no write path
        if (bus_wr_i) begin
            if (bus_addr_i == asp_pkg::ADDR_MODE) begin
                n.async_mode_reg = bus_wdata_i & asp_pkg::MODE_MASK;
            end else if (bus_addr_i == asp_pkg::ADDR_BRG) begin
                n.baud_gen_ctrl_reg = bus_wdata_i & asp_pkg::BRG_MASK;
            end else if (bus_addr_i == asp_pkg::ADDR_DATA) begin
                n.tx_shift_data = bus_wdata_i;
            end
        end

        // bus reads; transmit data and receive shifter never read back
        if (bus_rd_i) begin
            if (bus_addr_i == asp_pkg::ADDR_MODE) begin
                n.rd_data = r.async_mode_reg;
            end else if (bus_addr_i == asp_pkg::ADDR_STAT) begin
                n.rd_data = r.async_error_status_reg;
                n.async_error_status_reg = asp_pkg::RST_CTRL;
            end else if (bus_addr_i == asp_pkg::ADDR_BRG) begin
                n.rd_data = r.baud_gen_ctrl_reg;
            end else if (bus_addr_i == asp_pkg::ADDR_DATA) begin
                n.rd_data = r.rx_buffer_data;
                n.unread  = 1'b0;
            end
        end

        // transmitter; each bit lasts two half ticks
        case (r.tx_state)
            asp_pkg::TX_IDLE: begin
                if (tx_load && r.async_mode_reg[asp_pkg::MODE_TXE_BIT]) begin
                    n.tx_sh    = tx_word;
                    n.tx_cnt   = 3'h0;
                    n.tx_phase = 1'b0;
                    n.tx_par   = (ps == asp_pkg::PS_EVEN) ? ^tx_word
                               : (ps == asp_pkg::PS_ODD) ? ~^tx_word : 1'b0;
                    n.tx_state = asp_pkg::TX_START;
                end
            end
            default: begin
                if (tx_tick) begin
                    n.tx_phase = ~r.tx_phase;
                    if (r.tx_phase) begin
                        case (r.tx_state)
                            asp_pkg::TX_START: n.tx_state = asp_pkg::TX_DATA;
                            asp_pkg::TX_DATA: begin
                                n.tx_sh  = r.tx_sh >> 1;
                                n.tx_cnt = r.tx_cnt + 3'h1;
                                if (r.tx_cnt == last) begin
                                    n.tx_state = (ps == asp_pkg::PS_NONE) ? asp_pkg::TX_STOP1
                                                                          : asp_pkg::TX_PAR;
                                end
                            end
                            asp_pkg::TX_PAR:   n.tx_state = asp_pkg::TX_STOP1;
                            asp_pkg::TX_STOP1: begin
                                n.tx_state = r.async_mode_reg[asp_pkg::MODE_SL_BIT]
                                           ? asp_pkg::TX_STOP2 : asp_pkg::TX_IDLE;
                            end
                            default:           n.tx_state = asp_pkg::TX_IDLE;
                        endcase
                    end
                end
            end
        endcase
        if (!r.async_mode_reg[asp_pkg::MODE_TXE_BIT]) begin
            n.tx_state = asp_pkg::TX_IDLE;
        end
        case (n.tx_state)
            asp_pkg::TX_START: n.txd = 1'b0;
            asp_pkg::TX_DATA:  n.txd = n.tx_sh[0];
            asp_pkg::TX_PAR:   n.txd = n.tx_par;
            default:           n.txd = 1'b1;
        endcase

        // receiver; first half tick lands mid start bit, then every second one
        case (r.rx_state)
            asp_pkg::RX_IDLE: begin
                if (r.async_mode_reg[asp_pkg::MODE_RXE_BIT] && r.rx_prev && !line) begin
                    n.rx_state = asp_pkg::RX_START;
                    n.rx_cnt   = 3'h0;
                    n.rx_par   = 1'b0;
                end
            end
            asp_pkg::RX_START: begin
                if (rx_tick) begin
                    n.rx_phase = 1'b0;
                    n.rx_state = line ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
                end
            end
            default: begin
                if (rx_tick) begin
                    n.rx_phase = ~r.rx_phase;
                    if (r.rx_phase) begin
                        case (r.rx_state)
                            asp_pkg::RX_DATA: begin
                                n.rx_shift_reg = {line, r.rx_shift_reg[7:1]};
                                n.rx_par       = r.rx_par ^ line;
                                n.rx_cnt       = r.rx_cnt + 3'h1;
                                if (r.rx_cnt == last) begin
                                    n.rx_state = (ps == asp_pkg::PS_NONE) ? asp_pkg::RX_STOP
                                                                          : asp_pkg::RX_PAR;
                                end
                            end
                            asp_pkg::RX_PAR: begin
                                n.rx_par   = r.rx_par ^ line;
                                n.rx_state = asp_pkg::RX_STOP;
                            end
                            default: begin
                                rx_done    = 1'b1;
                                stop_ok    = line;
                                n.rx_state = asp_pkg::RX_IDLE;
                            end
                        endcase
                    end
                end
            end
        endcase

        // completion overrides a same-cycle read clear
        if (rx_done) begin
            stat[asp_pkg::STAT_PE_BIT]  = (ps == asp_pkg::PS_EVEN && r.rx_par)
                                       || (ps == asp_pkg::PS_ODD && !r.rx_par);
            stat[asp_pkg::STAT_FE_BIT]  = !stop_ok;
            stat[asp_pkg::STAT_OVE_BIT] = r.unread;
            n.async_error_status_reg = stat;
            n.rx_buffer_data = rx_word;
            n.unread = 1'b1;
        end
        if (!r.async_mode_reg[asp_pkg::MODE_RXE_BIT]) begin
            n.rx_state = asp_pkg::RX_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            r                <= '0;
            r.tx_shift_data  <= asp_pkg::RST_DATA;
            r.rx_buffer_data <= asp_pkg::RST_DATA;
            r.txd            <= 1'b1;
            r.rx_sync        <= 2'h3;
            r.rx_prev        <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign bus_rdata_o      = r.rd_data;
    assign serial_out_pin_o = r.txd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    stop_mode_idle_a: assert property (!r.async_mode_reg[asp_pkg::MODE_TXE_BIT]
        |=> r.tx_state == asp_pkg::TX_IDLE && serial_out_pin_o)
        else $error("transmitter active in stop mode");
    write_starts_tx_a: assert property (tx_load && r.async_mode_reg[asp_pkg::MODE_TXE_BIT]
        && r.tx_state == asp_pkg::TX_IDLE |=> !serial_out_pin_o)
        else $error("data write did not start a start bit");
    start_bit_low_a: assert property (r.tx_state == asp_pkg::TX_START
        |-> !serial_out_pin_o)
        else $error("start bit not low");
    zero_parity_a: assert property (r.tx_state == asp_pkg::TX_PAR && ps == asp_pkg::PS_ZERO
        |-> !serial_out_pin_o)
        else $error("zero parity bit not low");
    rx_msb_zero_a: assert property (rx_done && !r.async_mode_reg[asp_pkg::MODE_CL_BIT]
        |=> !r.rx_buffer_data[7])
        else $error("seven-bit receive left top bit set");
    buf_no_write_a: assert property (tx_load && !rx_done
        |=> $stable(r.rx_buffer_data))
        else $error("receive buffer changed by a write");
    framing_flag_a: assert property (rx_done && !stop_ok
        |=> r.async_error_status_reg[asp_pkg::STAT_FE_BIT])
        else $error("missing stop bit not flagged");
    overrun_flag_a: assert property (rx_done && r.unread
        |=> r.async_error_status_reg[asp_pkg::STAT_OVE_BIT] && r.unread)
        else $error("overrun not flagged");
    read_buf_a: assert property (bus_rd_i && bus_addr_i == asp_pkg::ADDR_DATA && !rx_done
        |=> bus_rdata_o == $past(r.rx_buffer_data) && !r.unread)
        else $error("data read did not return the receive buffer");

    tx_frame_c: cover property (r.tx_state == asp_pkg::TX_STOP2 ##1 r.tx_state == asp_pkg::TX_IDLE);
    rx_good_c:  cover property (rx_done && stop_ok && !r.unread);
    overrun_c:  cover property (rx_done && r.unread);
    framing_c:  cover property (rx_done && !stop_ok);

endmodule : asp_serial_port

// ### asp_remote_dev.sv
// far-end serial device model: sends frames and samples frames
`timescale 1ns/1ps
module asp_remote_dev #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic clock_i,
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;

    // ----------------------------------------------------------------
    // transmit side
    // ----------------------------------------------------------------
    task automatic send(input logic [7:0] d, input int nb, input logic hp, input logic p,
                        input logic stp);
        logic [11:0] f;
        int          n;
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < nb; i++) f[i + 1] = d[i];
        n = nb + 1;
        if (hp) begin
            f[n] = p;
            n++;
        end
        f[n] = stp;
        for (int i = 0; i <= n; i++) begin
            @(negedge clock_i);
            line_o = f[i];
            repeat (BIT_CLKS - 1) @(negedge clock_i);
        end
        // released line is pulled back to idle high
        @(negedge clock_i);
        line_o = 1'b1;
    endtask : send

    // ----------------------------------------------------------------
    // receive side: samples bit centres after the start edge
    // ----------------------------------------------------------------
    task automatic grab(input int cnt, output logic [11:0] b);
        int w;
        b = '1;
        w = 0;
        while (line_i !== 1'b0 && w < 4000) begin
            @(negedge clock_i);
            w++;
        end
        repeat (BIT_CLKS / 2) @(negedge clock_i);
        for (int i = 0; i < cnt; i++) begin
            repeat (BIT_CLKS) @(negedge clock_i);
            b[i] = line_i;
        end
    endtask : grab
endmodule : asp_remote_dev

// ### async_serial_port_tb.sv
// self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
module async_serial_port_tb;
    localparam int BITC = 64;
    logic        clock_i;
    logic        srst_i;
    logic [15:0] bus_addr_i;
    logic        bus_wr_i;
    logic        bus_rd_i;
    logic [7:0]  bus_wdata_i;
    logic [7:0]  bus_rdata_o;
    logic        rx_line;
    logic        tx_line;
    logic [11:0] fr;
    int          n_fail;
    int          total_checks;
    int          t;

    asp_serial_port u_dut (.clock_i(clock_i), .srst_i(srst_i), .bus_addr_i(bus_addr_i),
        .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
        .bus_rdata_o(bus_rdata_o), .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line));
    asp_remote_dev #(.BIT_CLKS(BITC)) u_far (.clock_i(clock_i), .line_i(tx_line),
        .line_o(rx_line));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock_i);
        bus_addr_i = a;
        bus_wdata_i = d;
        bus_wr_i = 1'b1;
        @(negedge clock_i);
        bus_wr_i = 1'b0;
    endtask : wr

    // read data is registered: settled by the falling edge after the read edge
    task automatic rd(input logic [15:0] a, input string nm, input logic [7:0] e);
        @(negedge clock_i);
        bus_addr_i = a;
        bus_rd_i = 1'b1;
        @(negedge clock_i);
        bus_rd_i = 1'b0;
        chk(nm, 16'(bus_rdata_o), 16'(e));
    endtask : rd

    function automatic logic [7:0] md(logic [1:0] ps, logic cl, logic sl);
        return {2'b11, ps, cl, sl, 2'b00};
    endfunction : md

    function automatic logic par(logic [1:0] ps, logic cl, logic [7:0] d);
        logic x;
        x = cl ? ^d : ^d[6:0];
        return (ps == asp_pkg::PS_EVEN) ? x : (ps == asp_pkg::PS_ODD) ? ~x : 1'b0;
    endfunction : par

    task automatic txchk(input logic [1:0] ps, input logic cl, input logic sl,
                         input logic [7:0] d);
        logic [11:0] e;
        int          nb;
        logic        hp;
        nb = cl ? 8 : 7;
        hp = (ps != asp_pkg::PS_NONE);
        e = '1;
        for (int i = 0; i < nb; i++) e[i] = d[i];
        if (hp) e[nb] = par(ps, cl, d);
        wr(asp_pkg::ADDR_MODE, md(ps, cl, sl));
        fork
            wr(asp_pkg::ADDR_DATA, d);
            u_far.grab(nb + 32'(hp) + 2, fr);
        join
        chk("tx frame", 16'(fr), 16'(e));
        // next write only once the stop bits have ended
        repeat (2 * BITC) @(negedge clock_i);
    endtask : txchk

    task automatic rxchk(input logic [1:0] ps, input logic cl, input logic [7:0] d,
                         input logic pf, input logic stp, input logic [7:0] eb,
                         input logic [7:0] es);
        wr(asp_pkg::ADDR_MODE, md(ps, cl, 1'b0));
        u_far.send(d, cl ? 8 : 7, ps != asp_pkg::PS_NONE, par(ps, cl, d) ^ pf, stp);
        repeat (4) @(negedge clock_i);
        rd(asp_pkg::ADDR_STAT, "rx status", es);
        rd(asp_pkg::ADDR_DATA, "rx buffer", eb);
    endtask : rxchk

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clock_i);
        n_fail++;
        conclude();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        n_fail = 0;
        total_checks = 0;
        srst_i = 1'b1;
        bus_addr_i = 16'h0000;
        bus_wr_i = 1'b0;
        bus_rd_i = 1'b0;
        bus_wdata_i = 8'h00;
        repeat (8) @(negedge clock_i);
        srst_i = 1'b0;
        rd(asp_pkg::ADDR_DATA, "rx buffer reset", asp_pkg::RST_DATA);
        rd(asp_pkg::ADDR_MODE, "mode reset", 8'h00);
        rd(asp_pkg::ADDR_STAT, "status reset", 8'h00);
        rd(asp_pkg::ADDR_BRG, "baud reset", 8'h00);
        chk("tx idle", 16'(tx_line), 16'h0001);
        wr(asp_pkg::ADDR_BRG, 8'h10);
        rd(asp_pkg::ADDR_BRG, "baud", 8'h10);
        // every mode bit is written; the masked bit 0 reads back as zero
        wr(asp_pkg::ADDR_MODE, 8'hFF);
        rd(asp_pkg::ADDR_MODE, "mode", 8'hFF & asp_pkg::MODE_MASK);
        wr(16'hFF9F, 8'h55);
        rd(16'hFF9F, "unmapped", 8'h00);
        // stop mode: a data write must not reach the line
        wr(asp_pkg::ADDR_MODE, 8'h00);
        wr(asp_pkg::ADDR_DATA, 8'h00);
        t = 0;
        repeat (BITC) begin
            @(negedge clock_i);
            if (tx_line !== 1'b1) t++;
        end
        chk("stop mode line", 16'(t), 16'h0000);
        rd(asp_pkg::ADDR_DATA, "shared address", asp_pkg::RST_DATA);
        txchk(asp_pkg::PS_EVEN, 1'b1, 1'b1, 8'hA5);
        txchk(asp_pkg::PS_ODD, 1'b0, 1'b0, 8'hC3);
        txchk(asp_pkg::PS_ZERO, 1'b1, 1'b0, 8'h81);
        txchk(asp_pkg::PS_NONE, 1'b0, 1'b1, 8'h7E);
        rxchk(asp_pkg::PS_EVEN, 1'b1, 8'h5A, 1'b0, 1'b1, 8'h5A, 8'h00);
        rxchk(asp_pkg::PS_ODD, 1'b0, 8'hFF, 1'b0, 1'b1, 8'h7F, 8'h00);
        rxchk(asp_pkg::PS_EVEN, 1'b1, 8'h3C, 1'b1, 1'b1, 8'h3C, 8'h04);
        rxchk(asp_pkg::PS_ZERO, 1'b1, 8'hC6, 1'b1, 1'b1, 8'hC6, 8'h00);
        rxchk(asp_pkg::PS_NONE, 1'b1, 8'h99, 1'b0, 1'b0, 8'h99, 8'h02);
        // overrun recurs until the buffer itself is read
        u_far.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
        u_far.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
        rd(asp_pkg::ADDR_STAT, "overrun", 8'h01);
        u_far.send(8'h33, 8, 1'b0, 1'b0, 1'b1);
        rd(asp_pkg::ADDR_STAT, "overrun again", 8'h01);
        rd(asp_pkg::ADDR_DATA, "newest char", 8'h33);
        u_far.send(8'h44, 8, 1'b0, 1'b0, 1'b1);
        rd(asp_pkg::ADDR_STAT, "no overrun", 8'h00);
        // music-interface rate: start bit length in clocks
        wr(asp_pkg::ADDR_MODE, md(asp_pkg::PS_NONE, 1'b1, 1'b0));
        wr(asp_pkg::ADDR_BRG, {1'b0, asp_pkg::MIDI_TPS, asp_pkg::MIDI_MDL});
        wr(asp_pkg::ADDR_DATA, 8'hFD);
        t = 0;
        while (tx_line === 1'b0 && t < 5000) begin
            t++;
            @(negedge clock_i);
        end
        chk("start bit clocks", 16'(t), 16'((2 ** (int'(asp_pkg::MIDI_TPS) + 1))
            * (int'(asp_pkg::MIDI_MDL) + 16) + 1));
        // clearing the enables aborts the frame at once
        wr(asp_pkg::ADDR_MODE, 8'h00);
        t = 0;
        repeat (1700) begin
            @(negedge clock_i);
            if (tx_line !== 1'b1) t++;
        end
        chk("abort line", 16'(t), 16'h0000);
        conclude();
    end
endmodule : async_serial_port_tb
